// ==== twm_master.sv ====
// twm_master: two-wire bus master with rate generator, bus-state tracker, address and
// data byte transmit, plus the byte fifo in front of it.
// assumes external pull-ups on scl/sda; pins are open drain, driven low only.
`timescale 1ns/1ps

// byte fifo between software writes and the transmit engine
module twm_fifo #(
   parameter int W = twm_pkg::FIFO_WIDTH,
   parameter int D = twm_pkg::FIFO_DEPTH
) (
   input  wire logic         clk,      // clock
   input  wire logic         rst,      // sync reset
   input  wire logic         in_valid, // writer has a word
   output logic              in_ready, // room left
   input  wire logic [W-1:0] in_data,  // word written
   output logic              out_valid,// word waiting
   input  wire logic         out_ready,// reader takes it
   output logic [W-1:0]      out_data  // head word
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } twm_fptr_t;
   twm_fptr_t      p_reg;
   twm_fptr_t      p_next;
   logic [W-1:0]   mem [D];
   logic           push;
   logic           pop;

   // extra pointer bit tells full from empty
   assign in_ready  = (p_reg.wp[AW] == p_reg.rp[AW]) || (p_reg.wp[AW-1:0] != p_reg.rp[AW-1:0]);
   assign out_valid = p_reg.wp != p_reg.rp;
   assign out_data  = mem[p_reg.rp[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer update
   always_comb
   begin
      p_next = p_reg;
      if (push)
         p_next.wp = p_reg.wp + (AW+1)'(1);
      if (pop)
         p_next.rp = p_reg.rp + (AW+1)'(1);
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge clk)
   begin
      if (push)
         mem[p_reg.wp[AW-1:0]] <= in_data;
      if (rst)
         p_reg <= '0;
      else
         p_reg <= p_next;
   end
endmodule : twm_fifo

module twm_master #(
   parameter int TO_CYC = twm_pkg::TO_BASE_CYC  // shortest inactivity time-out in cycles
) (
   input  wire logic       clk,                  // 100 MHz clock
   input  wire logic       rst,                  // sync reset, active high
   input  wire logic       master_enable,        // master on
   input  wire logic [7:0] master_rate_reg,      // baud divisor
   input  wire logic [1:0] timeout_sel,          // 0 off, 1/2/3 = x1/x2/x4
   input  wire logic       bus_state_wr,         // write strobe for state field
   input  wire logic [1:0] bus_state_wdata,      // value written
   input  wire logic       target_wr,            // write strobe for target
   input  wire logic [7:0] master_target_reg,    // address and direction
   input  wire logic       cmd_stop,             // stop command pulse
   input  wire logic       flags_clr,            // clear master flags pulse
   input  wire logic       byte_valid,           // data byte offered
   output logic            byte_ready,           // fifo has room
   input  wire logic [7:0] byte_data,            // data byte
   output logic [7:0]      master_byte_reg,      // byte in flight
   output logic [1:0]      bus_condition_field,  // bus state
   output logic            write_done_flag,      // write done
   output logic            peer_ack_flag,        // 1 = nack seen
   output logic            scl_stretch_flag,     // scl held
   output logic            arbitration_lost_flag,// arbitration lost
   output logic            bus_fault_flag,       // bus error
   input  wire logic       scl_i,                // scl level
   output logic            scl_o,                // scl drive value
   output logic            scl_oe_n,             // low = pull scl
   input  wire logic       sda_i,                // sda level
   output logic            sda_o,                // sda drive value
   output logic            sda_oe_n              // low = pull sda
);
   twm_pkg::twm_state_t s_reg;
   twm_pkg::twm_state_t s_next;
   logic        en;
   logic        scl_s;
   logic        sda_s;
   logic        start_det;
   logic        stop_det;
   logic        cnt_done;
   logic [8:0]  ph;
   logic [15:0] to_lim;
   logic        to_hit;
   logic        arb_hit;
   logic        err;
   logic        lost;
   logic        ack_end;
   logic        pop;
   logic        f_valid;
   logic [7:0]  f_data;

   twm_fifo #(
      .W (twm_pkg::FIFO_WIDTH),
      .D (twm_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (byte_valid),
      .in_ready  (byte_ready),
      .in_data   (byte_data),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data)
   );

   // condition detectors on the synchronised lines
   assign en        = master_enable;
   assign scl_s     = s_reg.scl_sy[1];
   assign sda_s     = s_reg.sda_sy[1];
   assign start_det = scl_s && s_reg.scl_q && s_reg.sda_q && !sda_s;
   assign stop_det  = scl_s && s_reg.scl_q && !s_reg.sda_q && sda_s;
   assign ph        = {1'b0, master_rate_reg} + twm_pkg::PHASE_ADD;
   assign cnt_done  = s_reg.cnt == twm_pkg::CNT_LAST;
   assign to_lim    = 16'(TO_CYC << (timeout_sel - 2'h1));
   assign to_hit    = timeout_sel != twm_pkg::TO_OFF && s_reg.idle_cnt >= to_lim;
   // released sda read low at bit end means another master won
   assign arb_hit   = s_reg.mst == twm_pkg::M_HIGH && scl_s && cnt_done
                      && s_reg.bitn != twm_pkg::ACK_BIT && !s_reg.sda_drv && !sda_s;
   // start or stop in the middle of a byte is a bus error
   assign err       = (s_reg.mst == twm_pkg::M_LOW || s_reg.mst == twm_pkg::M_HIGH)
                      && (start_det || stop_det);
   assign lost      = en && (arb_hit || err);
   assign ack_end   = en && !err && s_reg.mst == twm_pkg::M_HIGH && scl_s && cnt_done
                      && s_reg.bitn == twm_pkg::ACK_BIT;
   assign pop       = en && s_reg.mst == twm_pkg::M_HOLD && !s_reg.dir && !target_wr
                      && !cmd_stop && f_valid;

   // next state: flag clears first so a set in the same cycle wins
   always_comb
   begin
      s_next = s_reg;
      s_next.scl_sy = {s_reg.scl_sy[0], scl_i};
      s_next.sda_sy = {s_reg.sda_sy[0], sda_i};
      s_next.scl_q  = scl_s;
      s_next.sda_q  = sda_s;
      // inactivity counter restarts on any line movement and while disabled, so a fresh enable starts unknown
      if (!en || scl_s != s_reg.scl_q || sda_s != s_reg.sda_q)
         s_next.idle_cnt = '0;
      else if (!to_hit)
         s_next.idle_cnt = s_reg.idle_cnt + twm_pkg::IDLE_ONE;
      if (flags_clr)
      begin
         s_next.fl.write_done = 1'b0;
         s_next.fl.arb_lost   = 1'b0;
         s_next.fl.bus_fault  = 1'b0;
      end
      case (s_reg.mst)
         twm_pkg::M_IDLE:
            if (target_wr)
            begin
               s_next.mbyte         = master_target_reg;
               s_next.dir           = master_target_reg[0];
               s_next.fl.write_done = 1'b0;
               s_next.fl.arb_lost   = 1'b0;
               s_next.fl.bus_fault  = 1'b0;
               s_next.cnt           = ph;
               s_next.mst = (s_reg.bus == twm_pkg::BS_IDLE) ? twm_pkg::M_START : twm_pkg::M_WAIT;
            end
         twm_pkg::M_WAIT:
            if (s_reg.bus == twm_pkg::BS_IDLE)
            begin
               s_next.mst = twm_pkg::M_START;
               s_next.cnt = ph;
            end
         twm_pkg::M_START:
         begin
            s_next.sda_drv = 1'b1;
            s_next.cnt     = s_reg.cnt - twm_pkg::CNT_LAST;
            if (cnt_done)
            begin
               s_next.mst     = twm_pkg::M_LOW;
               s_next.scl_drv = 1'b1;
               s_next.bitn    = '0;
               s_next.cnt     = ph;
            end
         end
         twm_pkg::M_LOW:
         begin
            s_next.scl_drv = 1'b1;
            // sda moves only once scl reads low, so no false start or stop
            if (!scl_s)
               s_next.sda_drv = (s_reg.bitn == twm_pkg::ACK_BIT) ? 1'b0
                                : !s_reg.mbyte[3'(twm_pkg::MSB_BIT - s_reg.bitn)];
            s_next.cnt = s_reg.cnt - twm_pkg::CNT_LAST;
            if (cnt_done)
            begin
               s_next.mst     = twm_pkg::M_HIGH;
               s_next.scl_drv = 1'b0;
               s_next.cnt     = ph;
            end
         end
         twm_pkg::M_HIGH:
            // a slave stretching scl also pauses the high count
            if (scl_s)
            begin
               s_next.cnt = s_reg.cnt - twm_pkg::CNT_LAST;
               if (cnt_done && s_reg.bitn == twm_pkg::ACK_BIT)
               begin
                  s_next.mst        = twm_pkg::M_HOLD;
                  s_next.scl_drv    = 1'b1;
                  s_next.fl.stretch = 1'b1;
                  s_next.fl.peer_ack = sda_s;
                  if (!s_reg.dir || sda_s)
                     s_next.fl.write_done = 1'b1;
               end
               else if (cnt_done)
               begin
                  s_next.mst     = twm_pkg::M_LOW;
                  s_next.scl_drv = 1'b1;
                  s_next.bitn    = s_reg.bitn + twm_pkg::BIT_ONE;
                  s_next.cnt     = ph;
               end
            end
         twm_pkg::M_HOLD:
         begin
            s_next.scl_drv = 1'b1;
            if (target_wr)
            begin
               s_next.mbyte         = master_target_reg;
               s_next.dir           = master_target_reg[0];
               s_next.fl.write_done = 1'b0;
               s_next.fl.stretch    = 1'b0;
               s_next.sda_drv       = 1'b0;
               s_next.mst           = twm_pkg::M_RS1;
               s_next.cnt           = ph;
            end
            else if (cmd_stop)
            begin
               s_next.fl.stretch = 1'b0;
               s_next.sda_drv    = 1'b1;
               s_next.mst        = twm_pkg::M_STOP1;
               s_next.cnt        = ph;
            end
            else if (pop)
            begin
               s_next.mbyte         = f_data;
               s_next.fl.write_done = 1'b0;
               s_next.fl.stretch    = 1'b0;
               s_next.bitn          = '0;
               s_next.mst           = twm_pkg::M_LOW;
               s_next.cnt           = ph;
            end
         end
         twm_pkg::M_STOP1, twm_pkg::M_RS1:
         begin
            s_next.cnt = s_reg.cnt - twm_pkg::CNT_LAST;
            if (cnt_done)
            begin
               s_next.scl_drv = 1'b0;
               s_next.cnt     = ph;
               s_next.mst = (s_reg.mst == twm_pkg::M_RS1) ? twm_pkg::M_RS2 : twm_pkg::M_STOP2;
            end
         end
         twm_pkg::M_STOP2, twm_pkg::M_RS2:
            if (scl_s)
            begin
               s_next.cnt = s_reg.cnt - twm_pkg::CNT_LAST;
               if (cnt_done)
               begin
                  s_next.cnt     = ph;
                  s_next.sda_drv = 1'b0;                          // releasing sda makes the stop; in M_RS2 sda is already released for the repeated start
                  s_next.mst = (s_reg.mst == twm_pkg::M_RS2) ? twm_pkg::M_START : twm_pkg::M_STOP3;
               end
            end
         twm_pkg::M_STOP3:
         begin
            s_next.cnt = s_reg.cnt - twm_pkg::CNT_LAST;
            if (cnt_done)
               s_next.mst = twm_pkg::M_IDLE;
         end
         default:
            s_next.mst = twm_pkg::M_IDLE;
      endcase
      // lost arbitration or bus error drops the bus at once
      if (lost)
      begin
         s_next.fl.write_done = 1'b1;
         s_next.fl.arb_lost   = 1'b1;
         s_next.fl.bus_fault  = err || s_reg.fl.bus_fault;
         s_next.fl.stretch    = 1'b0;
         s_next.scl_drv       = 1'b0;
         s_next.sda_drv       = 1'b0;
         s_next.mst           = twm_pkg::M_IDLE;
      end
      // bus state tracker
      if (!en)
      begin
         s_next.bus     = twm_pkg::BS_UNKNOWN;
         s_next.mst     = twm_pkg::M_IDLE;
         s_next.scl_drv = 1'b0;
         s_next.sda_drv = 1'b0;
         s_next.fl.stretch = 1'b0;
      end
      else if (bus_state_wr && bus_state_wdata == twm_pkg::BS_IDLE)
         s_next.bus = twm_pkg::BS_IDLE;
      else if (lost)
         s_next.bus = twm_pkg::BS_BUSY;
      else if (stop_det)
         s_next.bus = twm_pkg::BS_IDLE;
      else if (to_hit && (s_reg.bus == twm_pkg::BS_UNKNOWN || s_reg.bus == twm_pkg::BS_BUSY))
         s_next.bus = twm_pkg::BS_IDLE;
      else if (start_det && s_reg.mst == twm_pkg::M_START)
         s_next.bus = twm_pkg::BS_OWNER;
      else if (start_det && s_reg.bus == twm_pkg::BS_IDLE)
         s_next.bus = twm_pkg::BS_BUSY;
   end

   // single state register; reset leaves the bus unknown
   always_ff @(posedge clk)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   // outputs straight from the state register; scl_o and sda_o are tied low
   assign bus_condition_field   = s_reg.bus;
   assign master_byte_reg       = s_reg.mbyte;
   assign write_done_flag       = s_reg.fl.write_done;
   assign peer_ack_flag         = s_reg.fl.peer_ack;
   assign scl_stretch_flag      = s_reg.fl.stretch;
   assign arbitration_lost_flag = s_reg.fl.arb_lost;
   assign bus_fault_flag        = s_reg.fl.bus_fault;
   assign scl_o                 = 1'b0;
   assign sda_o                 = 1'b0;
   assign scl_oe_n              = !s_reg.scl_drv;
   assign sda_oe_n              = !s_reg.sda_drv;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_disable_unknown: assert property (!en |=> s_reg.bus == twm_pkg::BS_UNKNOWN)
      else $error("bus state not unknown while disabled");
   a_force_idle: assert property (en && bus_state_wr && bus_state_wdata == twm_pkg::BS_IDLE |=> s_reg.bus == twm_pkg::BS_IDLE)
      else $error("idle write did not force idle");
   a_force_other: assert property (en && s_reg.bus == twm_pkg::BS_UNKNOWN && bus_state_wr && bus_state_wdata == twm_pkg::BS_OWNER |=> s_reg.bus != twm_pkg::BS_OWNER)
      else $error("owner state was forced by a write");
   a_stop_idle: assert property (en && stop_det && !lost |=> s_reg.bus == twm_pkg::BS_IDLE)
      else $error("stop did not give idle");
   a_ext_start: assert property (en && start_det && s_reg.bus == twm_pkg::BS_IDLE && s_reg.mst != twm_pkg::M_START && !bus_state_wr |=> s_reg.bus == twm_pkg::BS_BUSY)
      else $error("foreign start did not give busy");
   a_own_start: assert property (en && start_det && s_reg.mst == twm_pkg::M_START && !bus_state_wr |=> s_reg.bus == twm_pkg::BS_OWNER)
      else $error("own start did not give owner");
   a_lost_release: assert property (lost && !bus_state_wr |=> s_reg.bus == twm_pkg::BS_BUSY && s_reg.fl.arb_lost && s_reg.fl.write_done && scl_oe_n && sda_oe_n)
      else $error("lost arbitration not handled");
   a_error_fault: assert property (en && err |=> s_reg.fl.bus_fault && s_reg.fl.arb_lost)
      else $error("bus error not flagged");
   a_write_ack: assert property (ack_end && !sda_s && !s_reg.dir |=> s_reg.fl.write_done && !s_reg.fl.peer_ack && s_reg.fl.stretch && !scl_oe_n)
      else $error("acked write address flags wrong");
   a_read_ack: assert property (ack_end && !sda_s && s_reg.dir && !flags_clr |=> !s_reg.fl.peer_ack && s_reg.fl.stretch && !s_reg.fl.write_done)
      else $error("acked read address flags wrong");
   a_addr_nack: assert property (ack_end && sda_s |=> s_reg.fl.write_done && s_reg.fl.peer_ack && !scl_oe_n)
      else $error("nack flags wrong");
   a_byte_start: assert property (pop |=> !s_reg.fl.write_done && s_reg.mst == twm_pkg::M_LOW && s_reg.mbyte == $past(f_data))
      else $error("data byte not started");
   a_target_copy: assert property (en && s_reg.mst == twm_pkg::M_IDLE && target_wr |=> s_reg.mbyte == $past(master_target_reg))
      else $error("target not copied");
   a_wait_busy: assert property (en && s_reg.mst == twm_pkg::M_WAIT && s_reg.bus != twm_pkg::BS_IDLE |=> s_reg.mst == twm_pkg::M_WAIT)
      else $error("start issued on busy bus");
   a_low_length: assert property (en && !lost && s_reg.mst == twm_pkg::M_LOW && cnt_done |=> s_reg.mst == twm_pkg::M_HIGH && s_reg.cnt == ph && scl_oe_n)
      else $error("low phase length wrong");
   a_high_wait: assert property (en && !lost && s_reg.mst == twm_pkg::M_HIGH && !scl_s |=> s_reg.cnt == $past(s_reg.cnt))
      else $error("high phase counted before scl high");
   a_hold_scl: assert property (s_reg.fl.stretch |-> !scl_oe_n)
      else $error("scl released while held");

   c_write_ack: cover property (ack_end && !sda_s && !s_reg.dir);
   c_lost: cover property (lost);
   c_stop_done: cover property (s_reg.mst == twm_pkg::M_STOP3 ##1 s_reg.mst == twm_pkg::M_IDLE);
   c_data_byte: cover property (pop);
endmodule : twm_master

// ==== twm_pkg.sv ====
// twm_pkg: constants, encodings and state layout of the two-wire bus master.
// assumes a 100 MHz peripheral clock; every consumer names items as twm_pkg::name.
package twm_pkg;
   // clock and time figures
   localparam int          CLK_NS      = 10;
   localparam int          TO_BASE_NS  = 50000;                // shortest inactive-bus time-out
   localparam int          TO_BASE_CYC = TO_BASE_NS / CLK_NS;
   // scl phase arithmetic: the low half is rate + 5 cycles; the high half counts rate + 5 once scl reads high
   localparam logic [8:0]  PHASE_ADD   = 9'h005;
   localparam logic [8:0]  CNT_LAST    = 9'h001;
   localparam logic [3:0]  ACK_BIT     = 4'h8;                 // ninth bit slot of a packet
   localparam logic [3:0]  MSB_BIT     = 4'h7;
   localparam logic [3:0]  BIT_ONE     = 4'h1;
   localparam logic [15:0] IDLE_ONE    = 16'h0001;
   localparam logic [1:0]  TO_OFF      = 2'h0;
   localparam int          FIFO_WIDTH  = 8;
   localparam int          FIFO_DEPTH  = 8;

   typedef enum logic [1:0] {
      BS_UNKNOWN = 2'b00,
      BS_IDLE    = 2'b01,
      BS_BUSY    = 2'b10,
      BS_OWNER   = 2'b11
   } twm_bus_t;

   typedef enum logic [3:0] {
      M_IDLE  = 4'b0000,
      M_WAIT  = 4'b0001,
      M_START = 4'b0010,
      M_LOW   = 4'b0011,
      M_HIGH  = 4'b0100,
      M_HOLD  = 4'b0101,
      M_STOP1 = 4'b0110,
      M_STOP2 = 4'b0111,
      M_STOP3 = 4'b1000,
      M_RS1   = 4'b1001,
      M_RS2   = 4'b1010
   } twm_mst_t;

   typedef struct packed {
      logic write_done;
      logic peer_ack;
      logic stretch;
      logic arb_lost;
      logic bus_fault;
   } twm_flags_t;

   typedef struct packed {
      twm_bus_t   bus;
      twm_mst_t   mst;
      logic [8:0] cnt;
      logic [3:0] bitn;
      logic [7:0] mbyte;
      logic       dir;
      twm_flags_t fl;
      logic       scl_drv;
      logic       sda_drv;
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
      logic       scl_q;
      logic       sda_q;
      logic [15:0] idle_cnt;
   } twm_state_t;
endpackage : twm_pkg

// ==== twm_slave_model.sv ====
// twm_slave_model: behavioural bus slave that acks or nacks each byte.
// assumes the bench builds wired-and levels of scl and sda with pull-ups.
`timescale 1ns/1ps
module twm_slave_model (
   input  wire logic       scl,     // bus clock level
   input  wire logic       sda,     // bus data level
   input  wire logic       ack_en,  // 1 = answer with ack
   output logic            sda_n,   // low = pull sda
   output logic [7:0]      rx_byte  // last byte seen
);
   int cnt = 0;
   initial sda_n = 1'b1;
   initial rx_byte = 8'h00;
   // a start restarts the bit count
   always @(negedge sda) if (scl) cnt = 0;
   // msb first, sampled on rising scl
   always @(posedge scl)
   begin
      if (cnt < 8) rx_byte = {rx_byte[6:0], sda};
      cnt = cnt + 1;
   end
   // ack set and released only at falling scl, so it never looks like a start or stop
   always @(negedge scl)
   begin
      sda_n = !(cnt == 8 && ack_en);
      if (cnt == 9) cnt = 0;
   end
endmodule : twm_slave_model

// ==== twm_master_test.sv ====
// twm_master_test: self-checking bench, master against one slave model.
// assumes pull-ups on both lines; coll_n lets the bench pull sda as a rival.
`timescale 1ns/1ps
module twm_master_test;
   logic       clk = 1'b0, rst = 1'b1, master_enable = 1'b1, bus_state_wr = 1'b0, target_wr = 1'b0;
   logic       cmd_stop = 1'b0, flags_clr = 1'b0, byte_valid = 1'b0, ack_en = 1'b1, coll_n = 1'b1;
   logic [1:0] bus_state_wdata = 2'h1, bus_condition_field;
   logic [7:0] master_target_reg = 8'h00, byte_data = 8'h00, master_byte_reg, rx, a, d;
   logic       byte_ready, write_done_flag, peer_ack_flag, scl_stretch_flag, arbitration_lost_flag;
   logic       bus_fault_flag, scl_o, scl_oe_n, sda_o, sda_oe_n, sda_n, scl_i, sda_i, ew, ep;
   logic [10:0] rows [3] = '{{8'ha4, 3'b110}, {8'h5b, 3'b100}, {8'h3c, 3'b011}};
   int         error_cnt = 0, compares = 0, cyc = 0;
   logic [7:0] rate = 8'h2d, low_n = 8'h00, low_len = 8'h00;  // rate keeps the low phase at 500 ns or more
   logic [1:0] tsel = 2'h0;
   // wired-and bus levels
   assign scl_i = scl_oe_n;
   assign sda_i = sda_oe_n & sda_n & coll_n;
   always #5 clk = ~clk;
   twm_master #(.TO_CYC(20)) dut_u (.clk, .rst, .master_enable, .master_rate_reg(rate), .timeout_sel(tsel),
      .bus_state_wr, .bus_state_wdata, .target_wr, .master_target_reg, .cmd_stop, .flags_clr, .byte_valid,
      .byte_ready, .byte_data, .master_byte_reg, .bus_condition_field, .write_done_flag, .peer_ack_flag,
      .scl_stretch_flag, .arbitration_lost_flag, .bus_fault_flag, .scl_i, .scl_o, .scl_oe_n, .sda_i, .sda_o,
      .sda_oe_n);
   twm_slave_model slv_u (.scl(scl_i), .sda(sda_i), .ack_en, .sda_n, .rx_byte(rx));
   task end_sim;
      if (error_cnt == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         $display("BAD %0t got %h exp %h", $time, g, e);
         error_cnt++;
      end
   endtask : chk
   // one-cycle strobes {state write, target, stop, byte, clear}, data launched with them
   task strobe(input logic [4:0] m);
      @(posedge clk);
      {bus_state_wr, target_wr, cmd_stop, byte_valid, flags_clr} <= m;
      master_target_reg <= a;
      byte_data <= d;
      @(posedge clk);
      {bus_state_wr, target_wr, cmd_stop, byte_valid, flags_clr} <= 5'h00;
      #1;
   endtask : strobe
   // bounded wait: 0 stretch, 1 write done, 2 bus idle, 3 scl pulled
   task wt(input int s);
      logic hit;
      hit = 1'b0;
      for (int k = 0; k < 3000 && !hit; k++)
      begin
         @(posedge clk);
         #1;
         hit = (s == 0 && scl_stretch_flag === 1'b1) || (s == 1 && write_done_flag === 1'b1) ||
               (s == 2 && bus_condition_field === 2'h1) || (s == 3 && scl_oe_n === 1'b0);
      end
      // a wait that runs out is a mismatch, not a silent pass
      if (!hit)
      begin
         $display("BAD %0t got %h exp %h", $time, hit, 1'b1);
         error_cnt++;
      end
   endtask : wt
   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         end_sim();
      end
   end
   // length of the last finished scl low run pulled by the master
   always @(posedge clk)
   begin
      low_n <= scl_oe_n ? 8'h00 : low_n + 8'h01;
      if (scl_oe_n && low_n != 8'h00)
         low_len <= low_n;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk({bus_condition_field, write_done_flag, arbitration_lost_flag, sda_oe_n}, 8'h01);
      chk({scl_oe_n, scl_o, sda_o, byte_ready, peer_ack_flag, scl_stretch_flag, bus_fault_flag}, 8'h48);
      chk(master_byte_reg, 8'h00);
      foreach (rows[i])
      begin
         {a, ack_en, ew, ep} = rows[i];
         strobe(5'h10);
         chk(bus_condition_field, 8'h01);
         strobe(5'h08);
         chk(master_byte_reg, a);
         wt(0);
         chk({write_done_flag, peer_ack_flag, scl_stretch_flag, scl_oe_n}, {4'h0, ew, ep, 2'b10});
         chk(rx, a);
         chk(low_len, rate + 8'h05);
         chk(bus_condition_field, 8'h03);
         for (int j = 0; j < 2 && a[0] == 1'b0 && ep == 1'b0; j++)
         begin
            d = 8'hc3 ^ j;
            ack_en = (j == 0);
            strobe(5'h02);
            repeat (3) @(posedge clk);
            #1;
            chk(write_done_flag, 8'h00);
            wt(1);
            chk(rx, d);
            chk(peer_ack_flag, j);
         end
         strobe(5'h04);
         wt(2);
         chk(bus_condition_field, 8'h01);
         // the engine spends one more phase after the stop before it takes a target
         repeat (80) @(posedge clk);
      end
      // rival master pulls sda under a released address bit
      a = 8'hfe;
      strobe(5'h08);
      wt(3);
      @(posedge clk) coll_n <= 1'b0;
      wt(1);
      chk({write_done_flag, arbitration_lost_flag, bus_fault_flag, scl_oe_n, sda_oe_n}, 8'h1b);
      @(posedge clk) bus_state_wdata <= 2'h3;
      strobe(5'h10);
      chk(bus_condition_field, 8'h02);
      strobe(5'h01);
      chk({write_done_flag, arbitration_lost_flag, bus_fault_flag}, 8'h00);
      // a request on the still busy bus must wait for the rival's stop
      a = 8'h74;
      @(posedge clk) rate <= 8'h32;
      strobe(5'h08);
      repeat (20) @(posedge clk);
      #1;
      chk({scl_oe_n, sda_oe_n, bus_condition_field}, 8'h0e);
      @(posedge clk) coll_n <= 1'b1;
      wt(2);
      chk(bus_condition_field, 8'h01);
      wt(0);
      chk(rx, a);
      chk(low_len, rate + 8'h05);
      chk({write_done_flag, peer_ack_flag}, 8'h03);
      strobe(5'h04);
      wt(2);
      chk(bus_condition_field, 8'h01);
      @(posedge clk) master_enable <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(bus_condition_field, 8'h00);
      // re-enable with the shortest time-out: unknown first, idle once the lines sit still
      @(posedge clk)
      begin
         master_enable <= 1'b1;
         tsel          <= 2'h1;
      end
      repeat (2) @(posedge clk);
      #1;
      chk(bus_condition_field, 8'h00);
      repeat (25) @(posedge clk);
      #1;
      chk(bus_condition_field, 8'h01);
      end_sim();
   end
endmodule : twm_master_test
